// >>> bench/dtm_pins.sv
// far-side model: clock and capture pin pulser, output level monitor
// assumes pins idle low and are sampled on hclk
`timescale 1ns/1ps
module dtm_pins (
   input  wire logic       hclk,
   input  wire logic [1:0] tout,
   output logic [1:0]      clk_pin,
   output logic [1:0]      cap_pin
);
   initial begin
      clk_pin = 2'h0;
      cap_pin = 2'h0;
   end
   // three cycles per level so the two-flop synchroniser cannot miss one
   task pulse(input int cap, input int idx, input int n);
      repeat (n) begin
         @(posedge hclk);
         if (cap != 0) cap_pin[idx] <= 1'b1;
         else clk_pin[idx] <= 1'b1;
         repeat (3) @(posedge hclk);
         if (cap != 0) cap_pin[idx] <= 1'b0;
         else clk_pin[idx] <= 1'b0;
         repeat (3) @(posedge hclk);
      end
      repeat (4) @(posedge hclk); // last edge still in the synchroniser
   endtask : pulse
   // counts cycles with the output high, sampled after the edge settles
   task high_count(input int idx, input int n, output int hi);
      hi = 0;
      repeat (n) begin
         @(posedge hclk);
         #1;
         if (tout[idx] === 1'b1) hi++;
      end
   endtask : high_count
endmodule : dtm_pins

// >>> bench/dtm_props.sv
// checker of the dual timer top: bus answer, output pair, pin routing
// assumes one AHB-Lite master and sees the top's ports only
`timescale 1ns/1ps
`include "dtm_regs.svh"
module dtm_props #(
   parameter int CW      = 10,
   parameter int SUB_DIV = `DTM_SUB_DIV
) (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [1:0]  timer_clock_pin,
   input wire logic [1:0]  capture_input_pin,
   input wire logic [1:0]  timer_output,
   input wire logic [1:0]  timer_output_inverted,
   input wire logic [1:0]  timer_output_oe_n,
   input wire logic [1:0]  timer_output_inverted_oe_n,
   input wire logic        irq
);
   logic       wr_q;
   logic       bad_q;
   logic       hit;
   logic [7:0] adr_q;
   logic [7:0] pinsel_q;
   logic [3:0] mask_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // decoded places; misaligned reads are left out on purpose
   assign hit = (haddr[7:6] == 2'h0 && !haddr[4]) ||
                haddr[7:0] inside {`DTM_INT_ST_OFS, `DTM_INT_MASK_OFS,
                                   `DTM_PINSEL_OFS};
   // shadow of pinsel and mask, taken when the data phase closes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q     <= 1'b0;
         bad_q    <= 1'b0;
         adr_q    <= 8'h00;
         pinsel_q <= 8'h00;
         mask_q   <= 4'h0;
      end else begin
         wr_q  <= hsel && htrans[1] && hready && hwrite;
         bad_q <= hsel && htrans[1] && hready && !hwrite &&
                  haddr[1:0] == 2'h0 && !hit;
         adr_q <= haddr[7:0];
         if (wr_q && adr_q == `DTM_PINSEL_OFS) pinsel_q <= hwdata[7:0];
         if (wr_q && adr_q == `DTM_INT_MASK_OFS) mask_q <= hwdata[3:0];
      end
   end
   chk_out_inverse: assert property ($past(hresetn, 2) |->
      timer_output_inverted == ~timer_output)
      else $error("inverted output is not the inverse");
   chk_ready_high: assert property ($past(hresetn) |-> hreadyout)
      else $error("slave inserted a wait state");
   chk_resp_okay: assert property (!hresp)
      else $error("response is not okay");
   chk_unmapped_zero: assert property (bad_q |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_rdata_hold: assert property (
      !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   chk_oe_route: assert property ($stable(pinsel_q) |->
      timer_output_oe_n == ~{pinsel_q[6], pinsel_q[2]})
      else $error("output enable does not follow pinsel");
   chk_oeb_route: assert property ($stable(pinsel_q) |->
      timer_output_inverted_oe_n == ~{pinsel_q[7], pinsel_q[3]})
      else $error("inverted enable does not follow pinsel");
   chk_irq_masked: assert property ((mask_q == 4'h0)[*3] |-> !irq)
      else $error("irq high with all sources masked");
   cov_irq: cover property (irq);
   cov_out_rise: cover property ($rose(timer_output[0]));
   cov_bad_read: cover property (bad_q);
endmodule : dtm_props

bind dtm_top dtm_props #(.CW(CW), .SUB_DIV(SUB_DIV)) i_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .timer_clock_pin(timer_clock_pin),
   .capture_input_pin(capture_input_pin), .timer_output(timer_output),
   .timer_output_inverted(timer_output_inverted),
   .timer_output_oe_n(timer_output_oe_n),
   .timer_output_inverted_oe_n(timer_output_inverted_oe_n), .irq(irq));

// >>> bench/testbench.sv
// self-checking bench of the dual timer top over AHB-Lite
// assumes hready tied to hreadyout and the pin model on the far side
`timescale 1ns/1ps
`include "dtm_regs.svh"
module testbench;
   import dtm_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0]  htrans, tck, tcap, tout, toutb, toe_n, toeb_n;
   logic [2:0]  hsize;
   logic [7:0]  b;
   int          n_mismatch, checks_done, n, e;
   localparam logic [7:0] EC_C0[5] = '{8'h68, 8'h70, 8'h78, 8'hf8, 8'h78};
   localparam int EC_N[5] = '{5, 3, 3, 2, 2};
   localparam int EC_E[5] = '{5, 5, 3, 3, 5};
   localparam int DIV[6] = '{4, 1, 16, 64, 4, 4};
   dtm_top #(.CW(10), .SUB_DIV(4)) i_dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .timer_clock_pin(tck), .capture_input_pin(tcap),
      .timer_output(tout), .timer_output_inverted(toutb),
      .timer_output_oe_n(toe_n), .timer_output_inverted_oe_n(toeb_n),
      .irq(irq));
   dtm_pins i_pins (.hclk(hclk), .tout(tout), .clk_pin(tck),
      .cap_pin(tcap));
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   // one single word transfer; waits for hready in both phases
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, v);
   endtask : wr
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, v);
      chk(v, exp, "register read");
   endtask : rdchk
   task summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize
   // watchdog: the sequence needs well under 30000 cycles
   initial begin
      repeat (60000) @(posedge hclk);
      n_mismatch++;
      summarize();
   end
   initial begin
      {hsel, hwrite, haddr, hwdata, htrans} = '0;
      hsize = 3'b010;
      hresetn = 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      for (int t = 0; t < 2; t++)
         for (int r = 0; r < 4; r++) rdchk(8'(t * 32 + r * 4), 32'h0);
      for (int i = 0; i < 5; i++) rdchk(8'(8'h40 + i * 8'h4 + i * 12), 0);
      wr(`DTM_CMPA_OFS, 32'hffff_ffff);
      rdchk(`DTM_CMPA_OFS, 32'h3ff);
      wr(`DTM_COUNT_OFS, 32'h5);
      rdchk(`DTM_COUNT_OFS, 32'h0);
      $display("test reset and access done");
      // event counting: unrouted, then rise, off, fall, pause, resume
      for (int t = 0; t < 2; t++) begin
         b = 8'(t * 32);
         wr(b + `DTM_CTRL1_OFS, {DTM_MODE_TMR, 6'h0});
         wr(b, 32'h68);
         i_pins.pulse(0, t, 2);
         rdchk(b + `DTM_COUNT_OFS, 32'h0);
      end
      wr(`DTM_PINSEL_OFS, 32'h33);
      for (int t = 0; t < 2; t++)
         for (int r = 0; r < 5; r++) begin
            wr(8'(t * 32), EC_C0[r]);
            i_pins.pulse(0, t, EC_N[r]);
            rdchk(8'(t * 32 + 8), EC_E[r]);
         end
      $display("test event counter done");
      // internal clock codes over a span of 203 cycles
      wr(`DTM_CTRL0_OFS, 0);
      for (int c = 0; c < 6; c++) begin
         wr(`DTM_CTRL0_OFS, 32'h08 | (c << 4));
         repeat (200) @(posedge hclk);
         wr(`DTM_CTRL0_OFS, 32'h0);
         bus(1'b0, `DTM_COUNT_OFS, 32'h0, v);
         e = 203 / DIV[c];
         chk(v + 2 >= e && v <= e + 2, 1, "clock rate");
      end
      $display("test clock select done");
      // a match toggles, clears, raises its own source only
      wr(`DTM_CMPA_OFS, 32'd10);
      wr(`DTM_CTRL1_OFS, {DTM_MODE_CMP, 2'b11, 4'h1});
      wr(`DTM_INT_MASK_OFS, 32'h1);
      wr(`DTM_PINSEL_OFS, 32'hff);
      wr(`DTM_CTRL0_OFS, 32'h18);
      i_pins.high_count(0, 100, n);
      chk(n > 20 && n < 80, 1, "toggling output");
      chk(irq, 1'b1, "irq on a match");
      chk(toe_n, 2'b00, "output routed");
      wr(`DTM_CTRL0_OFS, 32'h0);
      rdchk(`DTM_INT_ST_OFS, 32'h1);
      wr(`DTM_INT_ST_OFS, 32'h1);
      rdchk(`DTM_INT_ST_OFS, 32'h0);
      chk(irq, 1'b0, "irq cleared");
      // p match every 128, masked then unmasked
      wr(`DTM_INT_MASK_OFS, 32'h0);
      wr(`DTM_CTRL1_OFS, {DTM_MODE_TMR, 6'h0});
      wr(`DTM_CTRL0_OFS, 32'h19);
      repeat (300) @(posedge hclk);
      chk(irq, 1'b0, "masked irq");
      bus(1'b0, `DTM_COUNT_OFS, 32'h0, v);
      chk(v < 128, 1, "p period");
      rdchk(`DTM_INT_ST_OFS, 32'h3);
      wr(`DTM_INT_MASK_OFS, 32'h2);
      repeat (3) @(posedge hclk);
      chk(irq, 1'b1, "unmasked irq");
      $display("test compare and interrupt done");
      // pwm with period 128 and duty 32
      wr(`DTM_CMPA_OFS, 32'd32);
      wr(`DTM_CTRL1_OFS, {DTM_MODE_PWM, 6'h0});
      repeat (300) @(posedge hclk);
      i_pins.high_count(0, 256, n);
      chk(n, 64, "pwm duty");
      // single pulse of about 20 cycles per trigger
      wr(`DTM_CMPA_OFS, 32'd20);
      wr(`DTM_CTRL1_OFS, {DTM_MODE_PWM, 2'b11, 4'h0});
      wr(`DTM_CTRL0_OFS, 32'h18);
      fork
         i_pins.pulse(0, 0, 1);
         i_pins.high_count(0, 60, n);
      join
      chk(n >= 18 && n <= 24, 1, "single pulse width");
      i_pins.high_count(0, 100, n);
      chk(n, 0, "no retrigger");
      $display("test pwm and pulse done");
      // periodic capture: each io code, then the clock pin
      wr(8'h20, 32'h18);
      for (int io = 0; io < 5; io++) begin
         wr(`DTM_INT_ST_OFS, 32'hf);
         wr(8'h24, {DTM_MODE_CAP, 2'(io > 3 ? 3 : io), 4'h0});
         i_pins.pulse(io > 3 ? 0 : 1, 1, 1);
         bus(1'b0, `DTM_INT_ST_OFS, 32'h0, v);
         chk(v[2], io != 3, "capture event");
      end
      $display("test capture done");
      summarize();
   end
endmodule : testbench

// >>> hw/dtm_pkg.sv
// types shared by the dual timer top and its timer core
// assumes dtm_regs.svh supplies all numeric constants
package dtm_pkg;

   typedef enum logic [1:0] {
      DTM_MODE_CMP = 2'b00,   // compare match output
      DTM_MODE_CAP = 2'b01,   // input capture
      DTM_MODE_PWM = 2'b10,   // pwm, or single pulse when io field is 11
      DTM_MODE_TMR = 2'b11    // plain timer / event counter
   } dtm_mode_t;

   typedef enum logic [2:0] {
      DTM_CK_SYS4  = 3'b000,
      DTM_CK_SYS   = 3'b001,
      DTM_CK_H16   = 3'b010,
      DTM_CK_H64   = 3'b011,
      DTM_CK_SUBA  = 3'b100,
      DTM_CK_SUBB  = 3'b101,
      DTM_CK_PINR  = 3'b110,
      DTM_CK_PINF  = 3'b111
   } dtm_cksel_t;

   typedef enum logic {
      DTM_SP_IDLE  = 1'b0,
      DTM_SP_PULSE = 1'b1
   } dtm_sp_t;

endpackage : dtm_pkg

// >>> hw/dtm_regs.svh
// register map, field positions, reset values and timing counts of the
// dual timer block; assumes 32-bit word aligned AHB-Lite register access
`ifndef DTM_REGS_SVH
`define DTM_REGS_SVH

// per-timer register offsets, timer n sits at n * stride
`define DTM_TMR_STRIDE   8'h20
`define DTM_CTRL0_OFS    8'h00
`define DTM_CTRL1_OFS    8'h04
`define DTM_COUNT_OFS    8'h08
`define DTM_CMPA_OFS     8'h0c
// shared registers
`define DTM_INT_ST_OFS   8'h40
`define DTM_INT_MASK_OFS 8'h44
`define DTM_PINSEL_OFS   8'h48

// control register 0 fields
`define DTM_C0_PAUSE     7
`define DTM_C0_CKSEL_LSB 4
`define DTM_C0_ON        3
`define DTM_C0_CMPP_LSB  0
// control register 1 fields
`define DTM_C1_MODE_LSB  6
`define DTM_C1_IO_LSB    4
`define DTM_C1_INIT      3
`define DTM_C1_POL       2
`define DTM_C1_DPX       1
`define DTM_C1_CCLR      0

// pin-share enable bits, four per timer
`define DTM_PS_CLK       0
`define DTM_PS_CAP       1
`define DTM_PS_OUT       2
`define DTM_PS_OUTB      3

`define DTM_CTRL_RST     8'h00
`define DTM_CMPA_RST     10'h000
`define DTM_PINSEL_RST   8'h00

// prescaler taps: sys/4, high clock/16 and /64 (high clock = hclk)
`define DTM_DIV4_MASK    6'h03
`define DTM_DIV16_MASK   6'h0f
`define DTM_DIV64_MASK   6'h3f
// sub clock approximated from the 50 MHz hclk, ~32.77 kHz
`define DTM_SUB_DIV      1526

`endif

// >>> hw/dtm_timer.sv
// one timer core: counter, comparators a and p, capture, output logic
// assumes pins already routed by pin-share and synchronous to hclk
`timescale 1ns/1ps
`include "dtm_regs.svh"
module dtm_timer #(
   parameter bit PERIODIC = 1'b0,
   parameter int CW       = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   dtm_tmr_if.core  tif
);
   import dtm_pkg::*;

   logic [2:0]    ck_s, cp_s;
   logic          on_q, out_q;
   logic [CW-1:0] cnt_q;
   dtm_sp_t       sp_q;
   dtm_mode_t     mode;
   dtm_cksel_t    cksel;
   logic [1:0]    io;
   logic          on, pause, tick, run, pin_edge, cap_evt, clr;
   logic          ck_rise, ck_fall, cp_rise, cp_fall, sp_mode, on_rise;
   logic          a_hit, p_hit, trig;
   logic [CW:0]   nxt;
   logic [CW-1:0] p_top, duty;

   assign mode    = dtm_mode_t'(tif.ctrl1[`DTM_C1_MODE_LSB +: 2]);
   assign io      = tif.ctrl1[`DTM_C1_IO_LSB +: 2];
   assign cksel   = dtm_cksel_t'(tif.ctrl0[`DTM_C0_CKSEL_LSB +: 3]);
   assign on      = tif.ctrl0[`DTM_C0_ON];
   assign pause   = tif.ctrl0[`DTM_C0_PAUSE];
   assign on_rise = on & ~on_q;
   assign sp_mode = (mode == DTM_MODE_PWM) && (io == 2'b11);

   // two-stage sync; edges read only stages two and three
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_s <= 3'h0;
         cp_s <= 3'h0;
      end else begin
         ck_s <= {ck_s[1:0], tif.clk_pin};
         cp_s <= {cp_s[1:0], tif.cap_pin};
      end
   end
   assign ck_rise = ck_s[1] & ~ck_s[2];
   assign ck_fall = ~ck_s[1] & ck_s[2];
   assign cp_rise = cp_s[1] & ~cp_s[2];
   assign cp_fall = ~cp_s[1] & cp_s[2];

   // counting clock selection
   always_comb begin
      case (cksel)
         DTM_CK_SYS4: tick = tif.ticks[0];
         DTM_CK_SYS:  tick = tif.ticks[1];
         DTM_CK_H16:  tick = tif.ticks[2];
         DTM_CK_H64:  tick = tif.ticks[3];
         DTM_CK_PINR: tick = ck_rise;
         DTM_CK_PINF: tick = ck_fall;
         default:     tick = tif.ticks[4];
      endcase
   end

   // single pulse counts only while its pulse is out
   assign run   = on & ~pause & (~sp_mode | (sp_q == DTM_SP_PULSE));
   assign nxt   = {1'b0, cnt_q} + {{CW{1'b0}}, 1'b1};
   // p compares top three bits; zero wraps at full overflow
   assign p_top = {tif.ctrl0[`DTM_C0_CMPP_LSB +: 3], {(CW-3){1'b0}}};
   assign p_hit = tick & run & (nxt[CW-1:0] == p_top);
   assign a_hit = tick & run & (nxt[CW-1:0] == tif.cmpa);

   // pwm: dpx low -> p sets period, a duty; dpx high -> swapped
   assign duty = tif.ctrl1[`DTM_C1_DPX] ? p_top : tif.cmpa;
   always_comb begin
      if (mode == DTM_MODE_PWM && !sp_mode)
         clr = tif.ctrl1[`DTM_C1_DPX] ? a_hit : p_hit;
      else
         clr = tif.ctrl1[`DTM_C1_CCLR] ? a_hit : p_hit;
   end

   // capture edge per io field; periodic type also takes clock pin
   always_comb begin
      case (io)
         2'b00:   pin_edge = cp_rise;
         2'b01:   pin_edge = cp_fall;
         2'b10:   pin_edge = cp_rise | cp_fall;
         default: pin_edge = 1'b0;
      endcase
      if (PERIODIC)
         pin_edge = pin_edge | ck_rise;
   end
   assign cap_evt = on & (mode == DTM_MODE_CAP) & pin_edge;
   // external trigger starts a single pulse; periodic too
   assign trig    = on & sp_mode & (sp_q == DTM_SP_IDLE) & ck_rise;

   // on/off edge tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         on_q <= 1'b0;
      else
         on_q <= on;
   end

   // counter: cleared on turn-on, held when off or paused
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         cnt_q <= '0;
      else if (on_rise || trig)
         cnt_q <= '0;
      else if (tick && run)
         cnt_q <= clr ? '0 : nxt[CW-1:0];
   end

   // single pulse sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         sp_q <= DTM_SP_IDLE;
      else begin
         case (sp_q)
            DTM_SP_IDLE:  if (trig) sp_q <= DTM_SP_PULSE;
            DTM_SP_PULSE: if (a_hit || !on || !sp_mode)
                             sp_q <= DTM_SP_IDLE;
            default:      sp_q <= DTM_SP_IDLE;
         endcase
      end
   end

   // output level per mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         out_q <= 1'b0;
      else if (on_rise && mode == DTM_MODE_CMP)
         out_q <= tif.ctrl1[`DTM_C1_INIT];
      else if (mode == DTM_MODE_CMP && a_hit) begin
         case (io)
            2'b01:   out_q <= 1'b0;
            2'b10:   out_q <= 1'b1;
            2'b11:   out_q <= ~out_q;
            default: out_q <= out_q;
         endcase
      end else if (sp_mode)
         out_q <= tif.ctrl1[`DTM_C1_POL] ^ (sp_q == DTM_SP_PULSE);
      else if (mode == DTM_MODE_PWM)
         out_q <= tif.ctrl1[`DTM_C1_POL] ^ (on & (cnt_q < duty));
   end

   assign tif.count   = cnt_q;
   assign tif.out     = out_q;
   assign tif.capture = cap_evt;
   assign tif.match_a = (mode == DTM_MODE_CAP) ? cap_evt : a_hit;
   assign tif.match_p = p_hit;
endmodule : dtm_timer

// >>> hw/dtm_tmr_if.sv
// signals between the register/bus top and one timer core
// assumes both ends run on hclk
`timescale 1ns/1ps
interface dtm_tmr_if #(parameter int CW = 10);
   logic [4:0]    ticks;     // sys/4, sys, h/16, h/64, sub enables
   logic [7:0]    ctrl0;
   logic [7:0]    ctrl1;
   logic [CW-1:0] cmpa;
   logic          clk_pin;
   logic          cap_pin;
   logic [CW-1:0] count;
   logic          match_a;   // comparator a match or capture event
   logic          match_p;
   logic          capture;   // load count into compare a
   logic          out;

   modport ctrl (output ticks, ctrl0, ctrl1, cmpa, clk_pin, cap_pin,
                 input count, match_a, match_p, capture, out);
   modport core (input ticks, ctrl0, ctrl1, cmpa, clk_pin, cap_pin,
                 output count, match_a, match_p, capture, out);
endinterface : dtm_tmr_if

// >>> hw/dtm_top.sv
// dual timer block: AHB-Lite registers, prescaler, interrupts, pin-share
// and the standard (index 0) and periodic (index 1) timer cores
// assumes single-word AHB-Lite transfers and pins synchronous to hclk
//
// Contract
// - counter equal to a comparator raises interrupt, may clear, may drive out
// - three-bit select picks system, high, sub or pin counter clock
// - each timer has separate comparator a and comparator p interrupts
// - software picks rising or falling edge of the external clock pin
// - in single pulse mode the clock pin triggers the pulse
// - capture pin edge is rising, falling or both via two-bit field
// - periodic timer also captures and triggers from its clock pin
// - second output is always the inverse of the first; in reset both are driven low
// - compare match sets output high, low or toggles it
// - pwm waveform leaves on the same true and inverted pair
// - pwm is edge aligned; duty or period adjusted, not both
// - one standard and one periodic timer, each with all five modes
// - selected clock pin edges advance the counter as event counter
// - timer pins connect only when pin-share routes them to timer
// - clock select codes: sys/4, sys, h/16, h/64, sub, pin edges
// - counter-on rising clears counter; falling stops and holds value
// - pause holds the counter; clearing pause resumes from held value
// - comparator p checks top three bits; zero means full overflow
`timescale 1ns/1ps
`include "dtm_regs.svh"
module dtm_top #(
   parameter int CW      = 10,
   parameter int SUB_DIV = `DTM_SUB_DIV
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [1:0]  timer_clock_pin,
   input  wire logic [1:0]  capture_input_pin,
   output logic [1:0]       timer_output,
   output logic [1:0]       timer_output_inverted,
   output logic [1:0]       timer_output_oe_n,
   output logic [1:0]       timer_output_inverted_oe_n,
   output logic             irq
);
   import dtm_pkg::*;

   localparam int NT = 2;   // standard then periodic

   logic [7:0]    ctrl0_q [NT];
   logic [7:0]    ctrl1_q [NT];
   logic [CW-1:0] cmpa_q  [NT];
   logic [31:0]   tmr_rd  [NT];
   logic [2*NT-1:0] st_q, mask_q, st_set;
   logic [7:0]    pinsel_q;
   logic [5:0]    pre_q;
   logic [11:0]   sub_q;
   logic          sub_tick;
   logic          wr_q;
   logic [7:0]    waddr_q;
   logic          addr_ok;
   logic [31:0]   rdata;

   // every access finishes with zero wait states and OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // address phase capture; hsize ignored since only words are used
   assign addr_ok = hsel & htrans[1] & hready & (hsize == 3'b010 | 1'b1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q    <= 1'b0;
         waddr_q <= 8'h00;
      end else begin
         wr_q    <= addr_ok & hwrite;
         waddr_q <= haddr[7:0];
      end
   end

   // read data is registered in the address phase so it stands in the
   // data phase; unmapped words read as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (addr_ok && !hwrite)
         hrdata <= rdata;
   end

   // prescaler: one-cycle enables for the internal clock ratios
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pre_q <= 6'h00;
      else
         pre_q <= pre_q + 6'h01;
   end

   // sub clock divider; coarse, since hclk is not a multiple of 32 kHz
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         sub_q <= 12'h000;
      else if (sub_tick)
         sub_q <= 12'h000;
      else
         sub_q <= sub_q + 12'h001;
   end
   assign sub_tick = (sub_q == 12'(SUB_DIV - 1));

   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_tmr
         localparam logic [7:0] BASE = 8'(gi * 32'h20);
         dtm_tmr_if #(.CW(CW)) tif ();

         // both timer kinds share one core, periodic adds pin capture
         dtm_timer #(
            .PERIODIC (gi == 1),
            .CW       (CW)
         ) u_tmr (
            .hclk    (hclk),
            .hresetn (hresetn),
            .tif     (tif)
         );

         // feed timer; pins pass only when pin-share routes them
         assign tif.ticks   = {sub_tick,
                               (pre_q & `DTM_DIV64_MASK) == `DTM_DIV64_MASK,
                               (pre_q & `DTM_DIV16_MASK) == `DTM_DIV16_MASK,
                               1'b1,
                               (pre_q & `DTM_DIV4_MASK) == `DTM_DIV4_MASK};
         assign tif.ctrl0   = ctrl0_q[gi];
         assign tif.ctrl1   = ctrl1_q[gi];
         assign tif.cmpa    = cmpa_q[gi];
         assign tif.clk_pin = timer_clock_pin[gi]
                              & pinsel_q[4*gi + `DTM_PS_CLK];
         assign tif.cap_pin = capture_input_pin[gi]
                              & pinsel_q[4*gi + `DTM_PS_CAP];
         assign st_set[2*gi]     = tif.match_a;
         assign st_set[2*gi + 1] = tif.match_p;

         // control registers
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ctrl0_q[gi] <= `DTM_CTRL_RST;
               ctrl1_q[gi] <= `DTM_CTRL_RST;
            end else if (wr_q) begin
               if (waddr_q == BASE + `DTM_CTRL0_OFS)
                  ctrl0_q[gi] <= hwdata[7:0];
               if (waddr_q == BASE + `DTM_CTRL1_OFS)
                  ctrl1_q[gi] <= hwdata[7:0];
            end
         end

         // compare a: a capture from the pin wins over a software write
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               cmpa_q[gi] <= `DTM_CMPA_RST;
            else if (tif.capture)
               cmpa_q[gi] <= tif.count;
            else if (wr_q && waddr_q == BASE + `DTM_CMPA_OFS)
               cmpa_q[gi] <= hwdata[CW-1:0];
         end

         // pin outputs registered; the pair is complementary except in reset, when both are low
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               timer_output[gi]               <= 1'b0;
               timer_output_inverted[gi]      <= 1'b0;
               timer_output_oe_n[gi]          <= 1'b1;
               timer_output_inverted_oe_n[gi] <= 1'b1;
            end else begin
               timer_output[gi]               <= tif.out;
               timer_output_inverted[gi]      <= ~tif.out;
               timer_output_oe_n[gi]          <=
                  ~pinsel_q[4*gi + `DTM_PS_OUT];
               timer_output_inverted_oe_n[gi] <=
                  ~pinsel_q[4*gi + `DTM_PS_OUTB];
            end
         end

         // per-timer read view
         always_comb begin
            tmr_rd[gi] = 32'h0000_0000;
            if (haddr[7:0] == BASE + `DTM_CTRL0_OFS)
               tmr_rd[gi] = {24'h00_0000, ctrl0_q[gi]};
            else if (haddr[7:0] == BASE + `DTM_CTRL1_OFS)
               tmr_rd[gi] = {24'h00_0000, ctrl1_q[gi]};
            else if (haddr[7:0] == BASE + `DTM_COUNT_OFS)
               tmr_rd[gi] = {{(32-CW){1'b0}}, tif.count};
            else if (haddr[7:0] == BASE + `DTM_CMPA_OFS)
               tmr_rd[gi] = {{(32-CW){1'b0}}, cmpa_q[gi]};
         end
      end
   endgenerate

   // sticky status: a new event wins over a write-one clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         st_q <= '0;
      else if (wr_q && waddr_q == `DTM_INT_ST_OFS)
         st_q <= (st_q & ~hwdata[2*NT-1:0]) | st_set;
      else
         st_q <= st_q | st_set;
   end

   // interrupt mask and pin-share selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q   <= '0;
         pinsel_q <= `DTM_PINSEL_RST;
      end else if (wr_q) begin
         if (waddr_q == `DTM_INT_MASK_OFS)
            mask_q <= hwdata[2*NT-1:0];
         if (waddr_q == `DTM_PINSEL_OFS)
            pinsel_q <= hwdata[7:0];
      end
   end

   // level interrupt, registered so the output comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq <= 1'b0;
      else
         irq <= |(st_q & mask_q);
   end

   // read mux: per-timer views plus shared registers
   always_comb begin
      case (haddr[7:0])
         `DTM_INT_ST_OFS:   rdata = {{(32-2*NT){1'b0}}, st_q};
         `DTM_INT_MASK_OFS: rdata = {{(32-2*NT){1'b0}}, mask_q};
         `DTM_PINSEL_OFS:   rdata = {24'h00_0000, pinsel_q};
         default:           rdata = tmr_rd[0] | tmr_rd[1];
      endcase
   end
endmodule : dtm_top
